//--- design/uartsf_regs.vh
`ifndef UARTSF_REGS_VH
`define UARTSF_REGS_VH

`define UARTSF_ADDR_STATUS 8'h00
`define UARTSF_ADDR_DATA 8'h04
`define UARTSF_ADDR_CTRL 8'h08
`define UARTSF_ADDR_IRQ_STAT 8'h0C
`define UARTSF_ADDR_IRQ_MASK 8'h10

`define UARTSF_BIT_TX_EMPTY 7
`define UARTSF_BIT_TX_DONE 6
`define UARTSF_BIT_RX_FULL 5
`define UARTSF_BIT_IDLE 4
`define UARTSF_BIT_OVR 3
`define UARTSF_BIT_NOISE 2

`define UARTSF_CTRL_BREAK 0
`define UARTSF_CTRL_IDLE_SEL 2
`define UARTSF_CTRL_TXON 3
`define UARTSF_CTRL_NINE 4
`define UARTSF_CTRL_WMASK 8'h1D
`define UARTSF_CTRL_RST 8'h00
`define UARTSF_MASK_RST 8'h00
`define UARTSF_IRQ_MASK_BITS 8'hFC

`define UARTSF_CHAR_BITS_8 4'hA
`define UARTSF_CHAR_BITS_9 4'hB
`define UARTSF_START_SAMPLES 3'h7
`define UARTSF_BIT_SAMPLES 3'h3

`endif

//--- design/uartsf_noise.v
`timescale 1ns/1ns
`default_nettype none
`include "uartsf_regs.vh"

module uartsf_noise (
  input wire sys_clk, // System clock.
  input wire rstn, // Synchronous reset, active low.
  input wire frame_begin, // Pulse at the falling edge that opens a frame.
  input wire sample_strobe, // Pulse for each sample taken inside a bit.
  input wire sample_bit, // Sampled line level.
  input wire bit_end, // Pulse closing each bit time.
  output reg frame_noise // High once any bit of the frame saw mixed samples.
);

  reg first_bit;
  reg [2:0] sample_cnt;
  reg seen_zero;
  reg seen_one;
  wire [2:0] sample_limit;

  // The start bit is judged on seven samples, every later bit on three.
  assign sample_limit = first_bit ? `UARTSF_START_SAMPLES : `UARTSF_BIT_SAMPLES;

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      first_bit <= 1'b1;
      sample_cnt <= 3'h0;
      seen_zero <= 1'b0;
      seen_one <= 1'b0;
      frame_noise <= 1'b0;
    end
    else if (frame_begin)
    begin
      first_bit <= 1'b1;
      sample_cnt <= 3'h0;
      seen_zero <= 1'b0;
      seen_one <= 1'b0;
      frame_noise <= 1'b0;
    end
    else if (bit_end)
    begin
      // A bit with both levels among its samples has a dissenting sample.
      if (seen_zero && seen_one)
      begin
        frame_noise <= 1'b1;
      end
      first_bit <= 1'b0;
      sample_cnt <= 3'h0;
      seen_zero <= 1'b0;
      seen_one <= 1'b0;
    end
    else if (sample_strobe && (sample_cnt < sample_limit))
    begin
      sample_cnt <= sample_cnt + 3'h1;
      if (sample_bit)
      begin
        seen_one <= 1'b1;
      end
      else
      begin
        seen_zero <= 1'b1;
      end
    end
  end

endmodule // uartsf_noise
`default_nettype wire

//--- design/uartsf_status.v
`timescale 1ns/1ns
`default_nettype none
`include "uartsf_regs.vh"

// Summary of operation
// - Transmit-empty flag is set at reset and when the buffer loads the shifter.
// - Transmit-empty clears only by status read seeing it set, then data write.
// - Transmit-complete is set at reset and when buffer empty and nothing sends.
// - Armed transmit-complete clears on data write, transmit enable rise, or break write.
// - Receive-full flag is set when a character enters the data register.
// - Receive-full clears by status read seeing it set, then data read.
// - Idle flag sets after the line stays high ten or eleven bit times.
// - Idle select zero starts idle counting right after the start bit.
// - Idle select one starts idle counting only after the stop bit.
// - Idle flag clears by status read seeing it set, then data read.
// - Idle flag sets once, then waits for a newly received character.
// - Overrun sets when a character arrives unread; new character and errors dropped.
// - Overrun clears by status read seeing it set, then data read.
// - Seven start-bit and three per-bit samples; any disagreement sets noise flag.
// - Noise clears by any status read followed by a data read.
module uartsf_status (
  input wire sys_clk, // System clock, 25 MHz.
  input wire rstn, // Synchronous reset, active low.
  input wire [7:0] paddr, // APB address.
  input wire psel, // APB select.
  input wire penable, // APB enable.
  input wire pwrite, // APB direction, high for write.
  input wire [31:0] pwdata, // APB write data.
  output reg [31:0] prdata, // APB read data.
  output wire pready, // APB ready, always high.
  output reg pslverr, // APB error for unmapped addresses.
  output wire irq, // Level interrupt.
  input wire rx_pin, // Serial receive line, asynchronous.
  input wire rx_bit_tick, // One pulse per bit time.
  input wire rx_frame_begin, // Pulse at the start bit falling edge.
  input wire rx_start_done, // Pulse at the end of the start bit.
  input wire rx_stop_done, // Pulse at the end of the stop bit.
  input wire rx_sample_strobe, // Pulse for each bit sample.
  input wire rx_sample_bit, // Level of that sample.
  input wire rx_bit_end, // Pulse closing each bit time.
  input wire rx_char_ready, // Pulse: shifter holds a complete character.
  input wire [7:0] rx_char_data, // Character in the shifter.
  input wire tx_shift_load, // Pulse: shifter takes the buffered word.
  input wire tx_active, // Level: data, preamble or break on the line.
  input wire [1:0] status_low_in, // Status bits 1 and 0 from other logic.
  output reg [7:0] tx_buf_data, // Transmit buffer contents.
  output wire tx_buf_valid, // Transmit buffer holds a word.
  output wire tx_on, // Transmit enable control.
  output wire send_break, // Send break control.
  output wire nine_bit_char // Nine bit character select.
);

  reg [1:0] rx_sync;
  reg tx_empty, tx_done, rx_full, idle, ovr, noise;
  reg arm_tx_empty, arm_tx_done, arm_rx_full, arm_idle, arm_ovr, arm_noise;
  reg tx_queued, idle_allow, idle_run;
  reg [3:0] idle_cnt;
  reg [7:0] rx_data, ctrl, irq_stat, irq_mask, flags_prev;

  wire frame_noise, rx_high, setup, access;
  wire [4:0] sel;
  wire st_rd, data_rd, data_wr, ctrl_wr, istat_wr, mask_wr;
  wire [7:0] status, flag_events;
  wire txon_rise, break_wr, tx_work, tx_done_clr;
  wire rx_take, rx_lost, idle_sel;
  wire [3:0] idle_target;
  wire idle_start, idle_hit;

  function [4:0] reg_sel;
    input [7:0] a;
    begin
      if (a == `UARTSF_ADDR_STATUS)
        reg_sel = 5'h01;
      else if (a == `UARTSF_ADDR_DATA)
        reg_sel = 5'h02;
      else if (a == `UARTSF_ADDR_CTRL)
        reg_sel = 5'h04;
      else if (a == `UARTSF_ADDR_IRQ_STAT)
        reg_sel = 5'h08;
      else if (a == `UARTSF_ADDR_IRQ_MASK)
        reg_sel = 5'h10;
      else
        reg_sel = 5'h00;
    end
  endfunction

  uartsf_noise uartsf_noise_inst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .frame_begin(rx_frame_begin),
    .sample_strobe(rx_sample_strobe),
    .sample_bit(rx_sample_bit),
    .bit_end(rx_bit_end),
    .frame_noise(frame_noise)
  );

  always @(posedge sys_clk)
  begin
    if (!rstn)
      rx_sync <= 2'h3;
    else
      rx_sync <= {rx_sync[0], rx_pin};
  end
  assign rx_high = rx_sync[1];

  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign sel = reg_sel(paddr);
  assign st_rd = access & ~pwrite & sel[0];
  assign data_rd = access & ~pwrite & sel[1];
  assign data_wr = access & pwrite & sel[1];
  assign ctrl_wr = access & pwrite & sel[2];
  assign istat_wr = access & pwrite & sel[3];
  assign mask_wr = access & pwrite & sel[4];

  assign status = {tx_empty, tx_done, rx_full, idle, ovr, noise, status_low_in};

  assign tx_on = ctrl[`UARTSF_CTRL_TXON];
  assign send_break = ctrl[`UARTSF_CTRL_BREAK];
  assign nine_bit_char = ctrl[`UARTSF_CTRL_NINE];
  assign idle_sel = ctrl[`UARTSF_CTRL_IDLE_SEL];
  assign tx_buf_valid = ~tx_empty;

  // Read data is captured in the setup cycle so the access cycle sees a
  // stable word; all clear sequences but noise's are armed from that captured word.
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= (sel == 5'h00);
      if (pwrite)
        prdata <= 32'h00000000;
      else if (sel[0])
        prdata <= {24'h000000, status};
      else if (sel[1])
        prdata <= {24'h000000, rx_data};
      else if (sel[2])
        prdata <= {24'h000000, ctrl};
      else if (sel[3])
        prdata <= {24'h000000, irq_stat};
      else if (sel[4])
        prdata <= {24'h000000, irq_mask};
      else
        prdata <= 32'h00000000;
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctrl <= `UARTSF_CTRL_RST;
      irq_mask <= `UARTSF_MASK_RST;
    end
    else
    begin
      if (ctrl_wr)
        ctrl <= pwdata[7:0] & `UARTSF_CTRL_WMASK;
      if (mask_wr)
        irq_mask <= pwdata[7:0] & `UARTSF_IRQ_MASK_BITS;
    end
  end

  // Arms other than noise's remember what the last status read showed; the matching data
  // access then completes the clear.
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      arm_tx_empty <= 1'b0;
      arm_tx_done <= 1'b0;
      arm_rx_full <= 1'b0;
      arm_idle <= 1'b0;
      arm_ovr <= 1'b0;
      arm_noise <= 1'b0;
    end
    else if (st_rd)
    begin
      arm_tx_empty <= prdata[`UARTSF_BIT_TX_EMPTY];
      arm_tx_done <= prdata[`UARTSF_BIT_TX_DONE];
      arm_rx_full <= prdata[`UARTSF_BIT_RX_FULL];
      arm_idle <= prdata[`UARTSF_BIT_IDLE];
      arm_ovr <= prdata[`UARTSF_BIT_OVR];
      arm_noise <= 1'b1;
    end
    else
    begin
      if (data_wr)
        arm_tx_empty <= 1'b0;
      if (tx_done_clr)
        arm_tx_done <= 1'b0;
      if (data_rd)
      begin
        arm_rx_full <= 1'b0;
        arm_idle <= 1'b0;
        arm_ovr <= 1'b0;
        arm_noise <= 1'b0;
      end
    end
  end

  // Transmit side.
  assign txon_rise = ctrl_wr & pwdata[`UARTSF_CTRL_TXON] & ~ctrl[`UARTSF_CTRL_TXON];
  assign break_wr = ctrl_wr & pwdata[`UARTSF_CTRL_BREAK];
  assign tx_work = (data_wr & arm_tx_empty) | txon_rise | break_wr;
  assign tx_done_clr = arm_tx_done & (data_wr | txon_rise | break_wr);

  always @(posedge sys_clk)
  begin
    if (!rstn)
      tx_buf_data <= 8'h00;
    else if (data_wr)
      tx_buf_data <= pwdata[7:0];
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
      tx_empty <= 1'b1;
    else if (tx_shift_load)
      tx_empty <= 1'b1;
    else if (data_wr && arm_tx_empty)
      tx_empty <= 1'b0;
  end

  // Queued work holds the complete flag low until the shifter reports
  // activity, which otherwise would lag the write by a bit time or more.
  always @(posedge sys_clk)
  begin
    if (!rstn)
      tx_queued <= 1'b0;
    else if (tx_work)
      tx_queued <= 1'b1;
    else if (tx_active)
      tx_queued <= 1'b0;
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
      tx_done <= 1'b1;
    else if (tx_done_clr)
      tx_done <= 1'b0;
    else if (tx_empty && !tx_active && !tx_queued)
      tx_done <= 1'b1;
  end

  // Receive side.
  assign rx_take = rx_char_ready & ~rx_full;
  assign rx_lost = rx_char_ready & rx_full;

  always @(posedge sys_clk)
  begin
    if (!rstn)
      rx_data <= 8'h00;
    else if (rx_take)
      rx_data <= rx_char_data;
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
      rx_full <= 1'b0;
    else if (rx_take)
      rx_full <= 1'b1;
    else if (data_rd && arm_rx_full)
      rx_full <= 1'b0;
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
      ovr <= 1'b0;
    else if (rx_lost)
      ovr <= 1'b1;
    else if (data_rd && arm_ovr)
      ovr <= 1'b0;
  end

  // A lost character leaves noise untouched, since its errors are dropped.
  always @(posedge sys_clk)
  begin
    if (!rstn)
      noise <= 1'b0;
    else if (rx_take)
      noise <= frame_noise;
    else if (data_rd && arm_noise)
      noise <= 1'b0;
  end

  // Idle detection.
  assign idle_target = nine_bit_char ? `UARTSF_CHAR_BITS_9 : `UARTSF_CHAR_BITS_8;
  assign idle_start = idle_sel ? rx_stop_done : rx_start_done;
  assign idle_hit = idle_run & rx_high & rx_bit_tick & (idle_cnt == idle_target - 4'h1);

  always @(posedge sys_clk)
  begin
    if (!rstn)
      idle_run <= 1'b0;
    else if (idle_hit)
      idle_run <= 1'b0;
    else if (idle_start)
      idle_run <= 1'b1;
    else if (!rx_high && idle_sel)
      idle_run <= 1'b0;
  end

  // A low bit restarts the count, so only an unbroken high stretch counts.
  always @(posedge sys_clk)
  begin
    if (!rstn)
      idle_cnt <= 4'h0;
    else if (!rx_high || !idle_run || idle_hit)
      idle_cnt <= 4'h0;
    else if (rx_bit_tick)
      idle_cnt <= idle_cnt + 4'h1;
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
      idle_allow <= 1'b0;
    else if (rx_take)
      idle_allow <= 1'b1;
    else if (idle_hit)
      idle_allow <= 1'b0;
  end

  always @(posedge sys_clk)
  begin
    if (!rstn)
      idle <= 1'b0;
    else if (idle_hit && idle_allow)
      idle <= 1'b1;
    else if (data_rd && arm_idle)
      idle <= 1'b0;
  end

  // Interrupts: each rising flag sets a sticky bit; a new event wins over
  // a write-one-to-clear in the same cycle.
  assign flag_events = status & ~flags_prev & `UARTSF_IRQ_MASK_BITS;

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      flags_prev <= 8'h00;
      irq_stat <= 8'h00;
    end
    else
    begin
      flags_prev <= status;
      if (istat_wr)
        irq_stat <= (irq_stat & ~pwdata[7:0]) | flag_events;
      else
        irq_stat <= irq_stat | flag_events;
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule // uartsf_status
`default_nettype wire

//--- verification/uartsf_status_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "uartsf_regs.vh"
module uartsf_status_asserts (
  input wire logic sys_clk, // Clock.
  input wire logic rstn, // Reset.
  input wire logic [7:0] paddr, // Address.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pslverr, // Error.
  input wire logic irq, // Interrupt.
  input wire logic tx_shift_load, // Shifter load.
  input wire logic [1:0] status_low_in, // Foreign bits.
  input wire logic [7:0] tx_buf_data, // Buffer word.
  input wire logic tx_buf_valid, // Buffer full.
  input wire logic tx_on, // Enable bit.
  input wire logic send_break, // Break bit.
  input wire logic nine_bit_char // Length bit.
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  wire setup = psel && !penable;
  wire st_rd = setup && !pwrite && paddr == `UARTSF_ADDR_STATUS;
  wire acc_wr = psel && penable && pwrite;
  wire dt_wr = acc_wr && paddr == `UARTSF_ADDR_DATA;
  wire ct_wr = acc_wr && paddr == `UARTSF_ADDR_CTRL;
  chk_load_empty: assert property (tx_shift_load |=> !tx_buf_valid)
    else $error("buffer still full after shifter load");
  chk_empty_hold: assert property ($fell(tx_buf_valid) |-> $past(tx_shift_load))
    else $error("buffer emptied without shifter load");
  chk_reset_empty: assert property ($rose(rstn) |-> !tx_buf_valid)
    else $error("buffer full out of reset");
  chk_fill_word: assert property ($rose(tx_buf_valid) |->
    $past(dt_wr) && tx_buf_data == $past(pwdata[7:0]))
    else $error("buffer filled without data write");
  chk_low_bits: assert property (st_rd |=> prdata[1:0] == $past(status_low_in))
    else $error("status bits 1 and 0 altered");
  chk_noise_full: assert property (st_rd |=> !prdata[2] || prdata[5])
    else $error("noise shown without full buffer");
  chk_ctrl_out: assert property (ct_wr |=> tx_on == $past(pwdata[3]) &&
    send_break == $past(pwdata[0]) && nine_bit_char == $past(pwdata[4]))
    else $error("control outputs differ from written value");
  chk_unmapped_err: assert property (setup && paddr > `UARTSF_ADDR_IRQ_MASK |=>
    pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  cover property (tx_shift_load);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule // uartsf_status_asserts
bind uartsf_status uartsf_status_asserts uartsf_status_asserts_inst (.sys_clk, .rstn,
  .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pslverr, .irq, .tx_shift_load,
  .status_low_in, .tx_buf_data, .tx_buf_valid, .tx_on, .send_break, .nine_bit_char);
`default_nettype wire

//--- verification/uartsf_remote.sv
`timescale 1ns/1ns
`default_nettype none
module uartsf_remote (
  input wire logic sys_clk, // Clock.
  output logic rx_pin, // Line.
  output logic rx_bit_tick, // Bit pulse.
  output logic rx_frame_begin, // Frame opens.
  output logic rx_start_done, // Start bit ends.
  output logic rx_stop_done, // Stop bit ends.
  output logic rx_sample_strobe, // Sample pulse.
  output logic rx_sample_bit, // Sample level.
  output logic rx_bit_end, // Bit closes.
  output logic rx_char_ready, // Character ready.
  output logic [7:0] rx_char_data // Character.
);
  initial
  begin
    {rx_bit_tick, rx_frame_begin, rx_start_done, rx_stop_done} = 4'h0;
    {rx_sample_strobe, rx_sample_bit, rx_bit_end, rx_char_ready} = 4'h0;
    rx_pin = 1'b1;
    rx_char_data = 8'h00;
  end
  // Two quiet cycles let the two-flop synchroniser settle before the tick.
  task automatic bit_time(input logic lvl, input int n, input logic nz, input logic sd,
    input logic pd);
    int k;
    rx_pin <= lvl;
    repeat (2) @(posedge sys_clk);
    {rx_bit_tick, rx_frame_begin} <= {1'b1, sd};
    @(posedge sys_clk);
    {rx_bit_tick, rx_frame_begin} <= 2'h0;
    for (k = 0; k < n; k++)
    begin
      rx_sample_strobe <= 1'b1;
      rx_sample_bit <= lvl ^ (nz && k == 0);
      @(posedge sys_clk);
    end
    rx_sample_strobe <= 1'b0;
    rx_sample_bit <= ~lvl;
    {rx_bit_end, rx_start_done, rx_stop_done} <= {1'b1, sd, pd};
    @(posedge sys_clk);
    {rx_bit_end, rx_start_done, rx_stop_done} <= 3'h0;
  endtask
  task automatic send_char(input logic [7:0] d, input logic nz);
    int k;
    bit_time(1'b0, 7, 1'b0, 1'b1, 1'b0);
    for (k = 0; k < 8; k++)
      bit_time(d[k], 3, nz && k == 0, 1'b0, 1'b0);
    bit_time(1'b1, 3, 1'b0, 1'b0, 1'b1);
    rx_char_ready <= 1'b1;
    rx_char_data <= d;
    @(posedge sys_clk);
    rx_char_ready <= 1'b0;
    rx_char_data <= ~d;
  endtask
  task automatic idle_bits(input int n);
    repeat (n) bit_time(1'b1, 0, 1'b0, 1'b0, 1'b0);
  endtask
endmodule // uartsf_remote
`default_nettype wire

//--- verification/uartsf_status_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "uartsf_regs.vh"
module uartsf_status_bench;
  localparam logic [7:0] ST = `UARTSF_ADDR_STATUS;
  localparam logic [7:0] DT = `UARTSF_ADDR_DATA;
  localparam logic [7:0] CT = `UARTSF_ADDR_CTRL;
  localparam logic [7:0] IS = `UARTSF_ADDR_IRQ_STAT;
  localparam logic [7:0] IM = `UARTSF_ADDR_IRQ_MASK;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic tx_shift_load = 1'b0;
  logic tx_active = 1'b0;
  logic [1:0] status_low_in = 2'h2;
  logic [31:0] prdata;
  logic [7:0] rx_char_data, tx_buf_data;
  logic pready, pslverr, irq, tx_buf_valid, tx_on, send_break, nine_bit_char;
  logic rx_pin, rx_bit_tick, rx_frame_begin, rx_start_done, rx_stop_done;
  logic rx_sample_strobe, rx_sample_bit, rx_bit_end, rx_char_ready;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  uartsf_status uartsf_status_inst (.sys_clk, .rstn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .irq, .rx_pin, .rx_bit_tick, .rx_frame_begin,
    .rx_start_done, .rx_stop_done, .rx_sample_strobe, .rx_sample_bit, .rx_bit_end,
    .rx_char_ready, .rx_char_data, .tx_shift_load, .tx_active, .status_low_in,
    .tx_buf_data, .tx_buf_valid, .tx_on, .send_break, .nine_bit_char);
  uartsf_remote uartsf_remote_inst (.sys_clk, .rx_pin, .rx_bit_tick, .rx_frame_begin,
    .rx_start_done, .rx_stop_done, .rx_sample_strobe, .rx_sample_bit, .rx_bit_end,
    .rx_char_ready, .rx_char_data);
  always #20 sys_clk = ~sys_clk;
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the bench timeout may end a wait for ready.
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    apb(1'b0, a, 8'h00, q);
    cmp(q, {24'h000000, e});
  endtask
  task automatic t_reset();
    rd(ST, 8'hC2);
    rd(CT, 8'h00);
    rd(8'h40, 8'h00);
    cmp(pslverr, 1'b1);
  endtask
  task automatic t_tx();
    logic [7:0] v;
    // The reset status read saw both transmit flags set, so this write clears them.
    wr(DT, 8'h11);
    cmp(tx_buf_valid, 1'b1);
    rd(ST, 8'h02);
    tx_active <= 1'b1;
    tx_shift_load <= 1'b1;
    @(posedge sys_clk);
    tx_shift_load <= 1'b0;
    @(posedge sys_clk);
    // The last status read saw the buffer full, so this write must not fill it.
    wr(DT, 8'h5A);
    cmp(tx_buf_valid, 1'b0);
    cmp(tx_buf_data, 8'h5A);
    rd(ST, 8'h82);
    tx_active <= 1'b0;
    @(posedge sys_clk);
    rd(ST, 8'hC2);
    // First pass raises the enable bit, second writes the break bit.
    for (v = 8'h08; v < 8'h0A; v++)
    begin
      wr(CT, v);
      rd(ST, 8'h82);
      tx_active <= 1'b1;
      @(posedge sys_clk);
      tx_active <= 1'b0;
      @(posedge sys_clk);
      rd(ST, 8'hC2);
    end
    wr(CT, 8'h00);
  endtask
  task automatic t_rx();
    uartsf_remote_inst.send_char(8'h3C, 1'b0);
    rd(ST, 8'hE2);
    uartsf_remote_inst.send_char(8'h11, 1'b0);
    rd(ST, 8'hEA);
    rd(DT, 8'h3C);
    rd(ST, 8'hC2);
    uartsf_remote_inst.send_char(8'h55, 1'b1);
    rd(ST, 8'hE6);
    rd(DT, 8'h55);
    rd(ST, 8'hC2);
  endtask
  task automatic t_idle(input logic [7:0] ctrl, input int n);
    wr(CT, ctrl);
    uartsf_remote_inst.send_char(8'hFF, 1'b0);
    uartsf_remote_inst.idle_bits(n);
    rd(ST, 8'hE2);
    uartsf_remote_inst.idle_bits(1);
    rd(ST, 8'hF2);
    rd(DT, 8'hFF);
    rd(ST, 8'hC2);
    uartsf_remote_inst.idle_bits(12);
    rd(ST, 8'hC2);
  endtask
  task automatic t_irq();
    wr(IS, 8'hFC);
    wr(IM, 8'h00);
    uartsf_remote_inst.send_char(8'h42, 1'b0);
    // The sticky bit follows the flag's rise by one cycle.
    @(posedge sys_clk);
    rd(IS, 8'h20);
    cmp(irq, 1'b0);
    wr(IM, 8'h20);
    cmp(irq, 1'b1);
    wr(IS, 8'h20);
    cmp(irq, 1'b0);
    rd(ST, 8'hE2);
    rd(DT, 8'h42);
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_tx();
    t_rx();
    t_idle(8'h00, 0);
    t_idle(8'h04, 9);
    t_idle(8'h14, 10);
    t_irq();
    end_of_test();
  end
endmodule // uartsf_status_bench
`default_nettype wire
